// ---- hdl/crd_framer.sv ----
`timescale 1ns/10ps
`include "crd_defines.svh"
module crd_framer (
	input  wire logic                        clk_sys_i,
	input  wire logic                        rst_i,
	input  wire logic                        ce_i,
	input  wire logic                        req_valid_i,
	output logic                             req_ready_o,
	input  wire crd_pkg::crd_req_type_s_type req_i,
	output logic                             desc_valid_o,
	input  wire logic                        desc_ready_i,
	output logic [127:0]                     desc_o,
	output logic                             desc_bad_o
);
	import crd_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic         in_ready;
		logic         out_valid;
		logic [3:0]   level;
		crd_desc_type out;
	} crd_state_type;

	crd_state_type st;
	crd_state_type next_st;
	crd_desc_type  built;
	logic          f_valid;
	logic          f_ready;
	crd_desc_type  f_data;
	logic          f_in_ready;

	// ----------------------------------------------------------------
	// Descriptor assembly
	// ----------------------------------------------------------------
	always_comb begin
		logic [2:0] bar;
		logic       is_msg;
		bar = req_i.bar_id;
		is_msg = 1'b0;
		built = '0;
		built.desc[`CRD_TYPE_LSB +: 4] = req_i.req_type;
		if (req_i.bar_is64)
			bar = {bar[2:1], 1'b0};
		if (!req_i.bar_hit)
			bar = req_i.root_port ? `CRD_BAR_NONE : `CRD_BAR_ROM;
		case (req_i.req_type)
			CRD_MEM_RD, CRD_MEM_WR, CRD_IO_RD, CRD_IO_WR,
			CRD_FETCHADD, CRD_SWAP, CRD_CAS, CRD_LOCK_RD: begin
				built.desc[74:0] = req_i.low_fields;
				built.desc[`CRD_BAR_LSB +: 3] = bar;
				built.desc[`CRD_APER_LSB +: 6] =
					req_i.bar_is_vf ? req_i.vf_aper : req_i.bar_aper;
				if (req_i.req_type == CRD_LOCK_RD && !req_i.legacy)
					built.bad = 1'b1;
			end
			CRD_MSG: begin
				is_msg = 1'b1;
				if (req_i.msg_kind == CRD_MK_LTR) begin
					built.desc[15:0] = req_i.snoop_lat;
					built.desc[`CRD_NSLAT_LSB +: 16] = req_i.nosnoop_lat;
				end else if (req_i.msg_kind == CRD_MK_OBFF) begin
					built.desc[`CRD_OBFF_LSB +: 4] = req_i.obff_code;
					if (req_i.obff_code != `CRD_OBFF_ACTIVE &&
					    req_i.obff_code != `CRD_OBFF_MEMPATH &&
					    req_i.obff_code != `CRD_OBFF_IDLE)
						built.bad = 1'b1;
				end
			end
			CRD_MSG_VD: begin
				is_msg = 1'b1;
				if (req_i.msg_route == `CRD_ROUTE_BY_ID)
					built.desc[15:0] = req_i.dest_id;
				built.desc[`CRD_VDH_LSB +: 32] = req_i.hdr_dw3;
			end
			CRD_MSG_ATS: begin
				is_msg = 1'b1;
				built.desc[63:0] = {req_i.hdr_dw3, req_i.hdr_dw2};
			end
			default: begin
				// Config and reserved codes still go out on this side, flagged bad
				built.bad = 1'b1;
			end
		endcase
		if (is_msg) begin
			// Dword count only; the bits below it carry the message fields
			built.desc[74:64] = req_i.low_fields[74:64];
			built.desc[`CRD_MCODE_LSB +: 8] = req_i.msg_code;
			built.desc[`CRD_BAR_LSB +: 3] = req_i.msg_route;
		end
		built.desc[`CRD_TC_LSB +: 3] = req_i.tc;
		built.desc[`CRD_ATTR_LSB +: 3] = req_i.attr;
		// ID-based ordering is only kept for memory reads, memory writes and messages
		if (!(is_msg || req_i.req_type == CRD_MEM_RD || req_i.req_type == CRD_MEM_WR))
			built.desc[`CRD_ATTR_IDO] = 1'b0;
	end

	// ----------------------------------------------------------------
	// Buffer between decode and output stage
	// ----------------------------------------------------------------
	crd_fifo #(
		.WIDTH ($bits(crd_desc_type)),
		.DEPTH (`CRD_FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.in_valid_i  (req_valid_i && st.in_ready),
		.in_ready_o  (f_in_ready),
		.in_data_i   (built),
		.out_valid_o (f_valid),
		.out_ready_i (f_ready),
		.out_data_o  (f_data)
	);

	// Output stage is a registered skid-free slot: refill when empty or taken
	assign f_ready = !st.out_valid || desc_ready_i;

	always_comb begin
		next_st = st;
		// Ready is registered, so it is worked out from the level after this edge
		next_st.level = st.level + 4'(req_valid_i && st.in_ready) - 4'(f_ready && f_valid);
		next_st.in_ready = (next_st.level != 4'(`CRD_FIFO_DEPTH));
		if (desc_ready_i && st.out_valid)
			next_st.out_valid = 1'b0;
		if (f_ready && f_valid) begin
			next_st.out_valid = 1'b1;
			next_st.out = f_data;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i)
			st <= '0;
		else if (ce_i)
			st <= next_st;
	end

	// The level counter mirrors the fifo, so ready never lags a full fifo
	assign req_ready_o  = st.in_ready;
	assign desc_valid_o = st.out_valid;
	assign desc_o       = st.out.desc;
	assign desc_bad_o   = st.out.bad;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_type_field;
		@(posedge clk_sys_i) disable iff (rst_i)
		desc_valid_o |-> desc_o[78:75] != 4'hF || desc_bad_o;
	endproperty
	a_type_field: assert property (p_type_field) else $error("reserved type not flagged");

	property p_cfg_bad;
		@(posedge clk_sys_i) disable iff (rst_i)
		desc_valid_o && desc_o[78] && !desc_o[77] |-> desc_bad_o;
	endproperty
	a_cfg_bad: assert property (p_cfg_bad) else $error("config type not flagged");

	property p_hold;
		@(posedge clk_sys_i) disable iff (rst_i)
		desc_valid_o && !desc_ready_i && ce_i |=> desc_valid_o && $stable(desc_o);
	endproperty
	a_hold: assert property (p_hold) else $error("descriptor changed while stalled");

	property p_ido;
		@(posedge clk_sys_i) disable iff (rst_i)
		desc_valid_o && desc_o[126] |-> desc_o[78:76] == 3'h0 || desc_o[78:77] == 2'h3;
	endproperty
	a_ido: assert property (p_ido) else $error("ID ordering on illegal type");

	property p_bar64;
		@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && req_valid_i && req_ready_o && req_i.bar_is64 && req_i.bar_hit
		&& !req_i.req_type[3] |-> built.desc[112] == 1'b0;
	endproperty
	a_bar64: assert property (p_bar64) else $error("64-bit BAR not even");

	property p_tc;
		@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && req_valid_i && req_ready_o |-> built.desc[123:121] == req_i.tc;
	endproperty
	a_tc: assert property (p_tc) else $error("traffic class lost");

	property p_mcode;
		@(posedge clk_sys_i) disable iff (rst_i)
		req_valid_i && req_i.req_type inside {CRD_MSG, CRD_MSG_VD, CRD_MSG_ATS}
		|-> built.desc[111:104] == req_i.msg_code && built.desc[114:112] == req_i.msg_route;
	endproperty
	a_mcode: assert property (p_mcode) else $error("message code or route wrong");

	property p_ats;
		@(posedge clk_sys_i) disable iff (rst_i)
		req_valid_i && req_i.req_type == CRD_MSG_ATS
		|-> built.desc[63:0] == {req_i.hdr_dw3, req_i.hdr_dw2};
	endproperty
	a_ats: assert property (p_ats) else $error("ATS header wrong");

	property p_zero_msg;
		@(posedge clk_sys_i) disable iff (rst_i)
		req_valid_i && req_i.req_type == CRD_MSG && req_i.msg_kind == CRD_MK_OTHER
		|-> built.desc[63:0] == 64'h0 && built.desc[120:115] == 6'h00;
	endproperty
	a_zero_msg: assert property (p_zero_msg) else $error("undefined bits not zero");

	property p_no_overrun;
		@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && req_valid_i && req_ready_o |-> f_in_ready;
	endproperty
	a_no_overrun: assert property (p_no_overrun) else $error("request taken into full fifo");
endmodule

// ---- pkg/crd_defines.svh ----
`ifndef CRD_DEFINES_SVH
`define CRD_DEFINES_SVH

`define CRD_DESC_W       128
`define CRD_TYPE_LSB     75
`define CRD_BAR_LSB      112
`define CRD_APER_LSB     115
`define CRD_TC_LSB       121
`define CRD_ATTR_LSB     124
`define CRD_ATTR_IDO     126
`define CRD_MCODE_LSB    104
`define CRD_OBFF_LSB     32
`define CRD_NSLAT_LSB    16
`define CRD_VDH_LSB      32
`define CRD_ROUTE_BY_ID  3'h2
`define CRD_BAR_ROM      3'h6
`define CRD_BAR_NONE     3'h7
`define CRD_OBFF_ACTIVE  4'hF
`define CRD_OBFF_MEMPATH 4'h1
`define CRD_OBFF_IDLE    4'h0
`define CRD_FIFO_DEPTH   8
`endif

// ---- pkg/crd_pkg.sv ----
package crd_pkg;
	typedef enum logic [3:0] {
		CRD_MEM_RD   = 4'h0,
		CRD_MEM_WR   = 4'h1,
		CRD_IO_RD    = 4'h2,
		CRD_IO_WR    = 4'h3,
		CRD_FETCHADD = 4'h4,
		CRD_SWAP     = 4'h5,
		CRD_CAS      = 4'h6,
		CRD_LOCK_RD  = 4'h7,
		CRD_CFG0_RD  = 4'h8,
		CRD_CFG1_RD  = 4'h9,
		CRD_CFG0_WR  = 4'hA,
		CRD_CFG1_WR  = 4'hB,
		CRD_MSG      = 4'hC,
		CRD_MSG_VD   = 4'hD,
		CRD_MSG_ATS  = 4'hE,
		CRD_RSVD     = 4'hF
	} crd_req_type;

	typedef enum logic [1:0] {
		CRD_MK_OTHER = 2'h0,
		CRD_MK_LTR   = 2'h1,
		CRD_MK_OBFF  = 2'h2
	} crd_msg_kind_type;

	// One decoded request as seen by the framer
	typedef struct packed {
		crd_req_type      req_type;
		crd_msg_kind_type msg_kind;
		logic             legacy;
		logic             root_port;
		logic             bar_hit;
		logic [2:0]       bar_id;
		logic             bar_is64;
		logic             bar_is_vf;
		logic [5:0]       bar_aper;
		logic [5:0]       vf_aper;
		logic [2:0]       tc;
		logic [2:0]       attr;
		logic [7:0]       msg_code;
		logic [2:0]       msg_route;
		logic [15:0]      snoop_lat;
		logic [15:0]      nosnoop_lat;
		logic [3:0]       obff_code;
		logic [15:0]      dest_id;
		logic [31:0]      hdr_dw2;
		logic [31:0]      hdr_dw3;
		logic [74:0]      low_fields;
		logic [0:0]       low_bit79;
	} crd_req_type_s_type;

	typedef struct packed {
		logic [127:0] desc;
		logic         bad;
	} crd_desc_type;
endpackage

// ---- hdl/crd_fifo.sv ----
`timescale 1ns/10ps
module crd_fifo #(
	parameter int WIDTH = 129,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];
	assign push        = ce_i && in_valid_i && in_ready_o;
	assign pop         = ce_i && out_valid_o && out_ready_i;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data_i;
				wr_ptr      <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ---- verification/crd_consumer.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Completer user logic taking descriptors
// ----------------------------------------
module crd_consumer (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_i,
	input  wire logic         stall_i,
	input  wire logic         slow_i,
	input  wire logic         desc_valid_i,
	input  wire logic [127:0] desc_i,
	output logic              desc_ready_o,
	output logic [5:0]        np_tc_attr_o
);
	logic phase;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			phase        <= 1'b0;
			desc_ready_o <= 1'b0;
			np_tc_attr_o <= 6'h00;
		end else begin
			phase        <= ~phase;
			desc_ready_o <= !stall_i && (!slow_i || phase);
			// Non-posted only: the completion must echo these unchanged
			if (desc_valid_i && desc_ready_o && !desc_i[78] && desc_i[78:75] != 4'h1) begin
				np_tc_attr_o <= desc_i[126:121];
			end
		end
	end
endmodule

// ---- verification/completer_request_descriptor_tb.sv ----
`timescale 1ns/10ps
module completer_request_descriptor_tb;
	import crd_pkg::*;
	logic               clk_sys_i = 1'b0;
	logic               rst_i = 1'b1;
	logic               req_valid_i = 1'b0;
	logic               stall = 1'b0;
	logic               slow = 1'b0;
	logic               ce = 1'b1;
	crd_req_type_s_type req_i = '0;
	logic               req_ready_o;
	logic               desc_valid_o;
	logic               desc_bad_o;
	logic               desc_ready;
	logic [127:0]       desc_o;
	logic [5:0]         np_ta;
	logic [128:0]       exp_q[$];
	logic [127:0]       msk_q[$];
	int                 n_mismatch = 0;
	int                 total_checks = 0;

	always #50 clk_sys_i = ~clk_sys_i;

	crd_framer dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
		.desc_valid_o(desc_valid_o), .desc_ready_i(desc_ready), .desc_o(desc_o),
		.desc_bad_o(desc_bad_o));
	crd_consumer sink (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .stall_i(stall), .slow_i(slow),
		.desc_valid_i(desc_valid_o), .desc_i(desc_o), .desc_ready_o(desc_ready),
		.np_tc_attr_o(np_ta));

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic chk_desc(input string nm, input logic [127:0] e, g, m);
		total_checks++;
		if ((g & m) !== (e & m)) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e & m, g & m);
		end
	endtask

	task automatic chk_bit(input string nm, input logic [7:0] e, g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// Only fields we can predict are masked in; bad types check the type alone
	function automatic void push(input crd_req_type_s_type r);
		logic [3:0]   t;
		logic [127:0] e;
		logic [127:0] m;
		logic         b;
		t = r.req_type;
		e = '0;
		m = '0;
		b = (t[3] && !t[2]) || t == 4'hF || (t == 4'h7 && !r.legacy) || (t == 4'hC &&
			r.msg_kind == CRD_MK_OBFF && !(r.obff_code inside {4'hF, 4'h1, 4'h0}));
		e[78:75] = t;
		m[79:75] = 5'h1F;
		if (!b && !t[3]) begin
			e[74:0] = r.low_fields;
			e[114:112] = !r.bar_hit ? (r.root_port ? 3'h7 : 3'h6) :
				r.bar_is64 ? {r.bar_id[2:1], 1'b0} : r.bar_id;
			e[120:115] = r.bar_is_vf ? r.vf_aper : r.bar_aper;
			e[126:121] = {r.attr[2] && t < 4'h2, r.attr[1:0], r.tc};
			m[127:112] = 16'hFFFF;
			m[74:0] = '1;
		end else if (!b) begin
			e[74:64] = r.low_fields[74:64];
			e[126:104] = {r.attr, r.tc, 6'h00, r.msg_route, r.msg_code};
			m[127:104] = 24'hFFFFFF;
			m[79:0] = '1;
			if (t == 4'hE) e[63:0] = {r.hdr_dw3, r.hdr_dw2};
			if (t == 4'hD) e[63:0] = {r.hdr_dw3, 16'h0000,
				r.msg_route == 3'h2 ? r.dest_id : 16'h0000};
			if (t == 4'hC && r.msg_kind == CRD_MK_LTR) e[31:0] = {r.nosnoop_lat, r.snoop_lat};
			if (t == 4'hC && r.msg_kind == CRD_MK_OBFF) e[35:32] = r.obff_code;
		end
		exp_q.push_back({e, b});
		msk_q.push_back(m);
	endfunction

	always @(posedge clk_sys_i) begin
		if (!rst_i && ce && desc_valid_o && desc_ready) begin
			if (exp_q.size() == 0) begin
				chk_bit("spare descriptor", 8'h00, 8'h01);
			end else begin
				chk_desc("descriptor", exp_q[0][128:1], desc_o, msk_q[0]);
				chk_bit("bad flag", {7'h00, exp_q[0][0]}, {7'h00, desc_bad_o});
				void'(exp_q.pop_front());
				void'(msk_q.pop_front());
			end
		end
	end

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	function automatic crd_req_type_s_type mk(input logic [3:0] t, input int k);
		mk = '0;
		mk.req_type = crd_req_type'(t);
		mk.bar_hit = 1'b1;
		mk.bar_id = 3'(k % 6);
		mk.bar_aper = 6'(12 + k);
		mk.vf_aper = 6'(30 - k);
		mk.tc = 3'(k);
		mk.attr = 3'(k + 5);
		mk.msg_code = 8'(8'h30 + k);
		mk.msg_route = 3'(k);
		mk.snoop_lat = 16'h1234;
		mk.nosnoop_lat = 16'hC0DE;
		mk.dest_id = 16'hA55A;
		mk.hdr_dw2 = 32'h0BADF00D ^ 32'(k);
		mk.hdr_dw3 = 32'h7E570C0D;
		mk.low_fields = {11'h2A5, 64'hFEDCBA9876543210 ^ 64'(k)};
	endfunction

	// Valid stays up after the take; back-to-back calls set it high again without dropping it
	task automatic send(input crd_req_type_s_type r);
		int n;
		push(r);
		req_i <= r;
		req_valid_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (!req_ready_o && n < 50);
		if (n >= 50) chk_bit("request taken", 8'h01, 8'h00);
	endtask

	task automatic drain;
		int n;
		req_valid_i <= 1'b0;
		for (n = 0; n < 300 && exp_q.size() != 0; n++) @(negedge clk_sys_i);
		chk_bit("all delivered", 8'h00, 8'(exp_q.size()));
		@(posedge clk_sys_i);
	endtask

	task automatic t_types;
		crd_req_type_s_type r;
		for (int t = 0; t < 16; t++) send(mk(4'(t), t));
		r = mk(4'h7, 7);
		r.legacy = 1'b1;
		send(r);
		drain;
	endtask

	task automatic t_bar;
		crd_req_type_s_type r;
		for (int k = 0; k < 8; k++) begin
			r = mk(4'h0, k);
			r.bar_is64 = k[1];
			r.bar_is_vf = k[0];
			r.bar_hit = k < 6;
			r.root_port = k == 7;
			send(r);
		end
		drain;
		chk_bit("echoed tc attr", {2'h0, r.attr, r.tc}, {2'h0, np_ta});
	endtask

	task automatic t_msgs;
		crd_req_type_s_type r;
		logic [3:0]         oc[4] = '{4'hF, 4'h1, 4'h0, 4'h5};
		r = mk(4'hC, 1);
		r.msg_kind = CRD_MK_LTR;
		send(r);
		for (int c = 0; c < 4; c++) begin
			r = mk(4'hC, c);
			r.msg_kind = CRD_MK_OBFF;
			r.obff_code = oc[c];
			send(r);
		end
		send(mk(4'hD, 2));
		send(mk(4'hD, 3));
		send(mk(4'hE, 4));
		send(mk(4'hC, 5));
		send(mk(4'h1, 6));
		drain;
	endtask

	// Offered while the clock enable is low: nothing may move
	task automatic t_ce;
		ce <= 1'b0;
		req_i <= mk(4'h0, 1);
		req_valid_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		chk_bit("frozen output", 8'h00, {7'h00, desc_valid_o});
		chk_bit("frozen ready", 8'h01, {7'h00, req_ready_o});
		push(mk(4'h0, 1));
		ce <= 1'b1;
		@(posedge clk_sys_i);
		drain;
	endtask

	task automatic t_fifo;
		int k;
		stall <= 1'b1;
		k = 0;
		repeat (20) begin
			req_i <= mk(4'h1, k);
			req_valid_i <= 1'b1;
			@(posedge clk_sys_i);
			if (req_ready_o) begin
				push(mk(4'h1, k));
				k++;
			end
		end
		chk_bit("ready when full", 8'h00, {7'h00, req_ready_o});
		chk_bit("taken while stalled", 8'h01, {7'h00, k inside {8, 9}});
		slow <= 1'b1;
		stall <= 1'b0;
		drain;
	endtask

	initial begin
		#2000000;
		n_mismatch++;
		end_of_test;
	end

	initial begin
		repeat (12) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		t_types;
		t_bar;
		t_msgs;
		t_ce;
		t_fifo;
		end_of_test;
	end
endmodule
